// ==== hdl/rbmm_top.sv ====
// Notes on behaviour
// - motor control peripheral registers decode in data space from 0x2000.
// - flash sectors of 256, 256, 3584 words in external program space.
// - four 16-bit flash interface registers readable; software writes ignored.
// - four nonvolatile 8-bit spare bytes, separate access, erase to zero.
// - boot code set: boot from flash, refuse programming utility access.
// - boot code cleared only by ROM call: erase-then-clear or clear-keep.
// - reset starts at ROM 0x0800; set code jumps to flash 0x2200.
// - code not set: monitor loads program from external device.
// - cycle clock pulses at twice the input clock frequency.
// - reset held while supply low, then 2^16 more cycles.
// - external reset pin low after power-up forces full reset.
// - reset holds core and peripherals, returns system and wait control to defaults.
// - system control bit 10 selects serial port, else flags and lines.
//
// The implementer's own choice: the address-and-strobe port.
`include "rbmm_cfg.svh"

module rbmm_top #(
   parameter int POR_EXT_CYCLES = `RBMM_POR_EXT_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        supply_ok,
   input  wire logic        ext_reset_n,
   input  wire logic        input_clock_pin,
   input  wire logic [13:0] reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   input  wire logic [15:0] peri_rdata,
   output logic             peri_wr,
   output logic             peri_rd,
   input  wire logic [13:0] pm_addr,
   output logic             pm_sel_ram,
   output logic             pm_sel_rom,
   output logic             pm_sel_flash,
   output logic             pm_sel_rsvd,
   output logic      [1:0]  pm_flash_sector,
   input  wire logic        boot_code_nv,
   output logic             boot_code_clear,
   output logic             flash_erase_req,
   input  wire logic        flash_erase_done,
   output logic             ext_load_req,
   output logic      [13:0] boot_pc,
   output logic             boot_pc_valid,
   input  wire logic        ep_wr,
   input  wire logic        ep_rd,
   input  wire logic        ep_erase_spare,
   input  wire logic [2:0]  ep_addr,
   input  wire logic [15:0] ep_wdata,
   output logic      [15:0] ep_rdata,
   output logic             ep_refused,
   output logic             core_reset_n,
   output logic             periph_reset_n,
   output logic             cycle_clock_output,
   output logic             sync_serial_port_sel,
   output logic      [15:0] wait_state_control
);
   localparam logic [16:0] POR_LAST = 17'(POR_EXT_CYCLES - 1);

   rbmm_pkg::rbmm_state_t s_q;
   rbmm_pkg::rbmm_state_t s_d;
   logic [15:0] dm_ram [0:`RBMM_DM_RAM_WORDS-1];
   logic [2:0]  pins_s;
   logic        supply_s;
   logic        pin_rst_n_s;
   logic        clk_in_s;
   logic        in_dm_ram;
   logic        in_peri;
   logic [8:0]  ram_idx;

   // pins are asynchronous to clk
   rbmm_sync #(.W(3)) u_sync (
      .clk      (clk),
      .rst_n    (rst_n),
      .async_in ({input_clock_pin, ext_reset_n, supply_ok}),
      .sync_out (pins_s)
   );
   assign supply_s    = pins_s[0];
   assign pin_rst_n_s = pins_s[1];
   assign clk_in_s    = pins_s[2];

   assign in_peri   = reg_addr >= `RBMM_DM_PERI_LO &&
                      reg_addr <= `RBMM_DM_PERI_HI;
   assign in_dm_ram = reg_addr >= `RBMM_DM_RAM_LO &&
                      reg_addr <= `RBMM_DM_RAM_HI;
   assign ram_idx   = reg_addr[`RBMM_DM_RAM_IW-1:0];

   // ram kept apart from the state word, it is an array
   always_ff @(posedge clk) begin
      if (reg_wr && in_dm_ram) begin
         dm_ram[ram_idx] <= reg_wdata;
      end
   end

   always_comb begin
      s_d = s_q;
      s_d.peri_wr    = 1'b0;
      s_d.peri_rd    = 1'b0;
      s_d.code_clear = 1'b0;
      s_d.ep_refused = 1'b0;
      s_d.cyc_pulse  = 1'b0;
      s_d.rdata      = 16'h0000;

      if (!supply_s || !pin_rst_n_s) begin
         s_d.por_cnt  = 17'h00000;
         s_d.rst_hold = 1'b1;
      end else if (s_q.rst_hold) begin
         if (s_q.por_cnt >= POR_LAST) begin
            s_d.rst_hold = 1'b0;
         end else begin
            s_d.por_cnt = s_q.por_cnt + 17'h00001;
         end
      end

      // one cycle pulse per input edge
      s_d.clk_in_last = clk_in_s;
      if (clk_in_s != s_q.clk_in_last) begin
         s_d.cyc_pulse = 1'b1;
      end

      s_d.pm_ram    = pm_addr <= `RBMM_PM_RAM_HI;
      s_d.pm_rom    = pm_addr >= `RBMM_PM_ROM_LO &&
                      pm_addr <= `RBMM_PM_ROM_HI;
      s_d.pm_flash  = pm_addr >= `RBMM_PM_FL0_LO &&
                      pm_addr <= `RBMM_PM_FL2_HI;
      s_d.pm_rsvd   = !(s_d.pm_ram || s_d.pm_rom || s_d.pm_flash);
      s_d.pm_sector = `RBMM_SECT0;
      if (pm_addr >= `RBMM_PM_FL2_LO) begin
         s_d.pm_sector = `RBMM_SECT2;
      end else if (pm_addr >= `RBMM_PM_FL1_LO) begin
         s_d.pm_sector = `RBMM_SECT1;
      end

      // boot sequencer
      case (s_q.boot)
         rbmm_pkg::BT_HOLD: begin
            s_d.pc_valid     = 1'b0;
            s_d.ext_load_req = 1'b0;
            // nonvolatile code is caught while reset holds
            s_d.boot_code    = boot_code_nv;
            if (!s_q.rst_hold) begin
               s_d.pc       = `RBMM_ROM_ENTRY;
               s_d.pc_valid = 1'b1;
               s_d.boot     = rbmm_pkg::BT_ROM;
            end
         end
         rbmm_pkg::BT_ROM: begin
            // monitor checks code: set jumps to flash, clear requests external load
            if (s_q.boot_code) begin
               s_d.pc   = `RBMM_FLASH_ENTRY;
               s_d.boot = rbmm_pkg::BT_FLASH;
            end else begin
               s_d.ext_load_req = 1'b1;
               s_d.boot         = rbmm_pkg::BT_EXT;
            end
         end
         rbmm_pkg::BT_FLASH: begin
            // user code calls a clearing routine
            if (reg_wr && reg_addr == `RBMM_BOOT_CTRL) begin
               if (reg_wdata == `RBMM_CMD_ERASE_CLR) begin
                  s_d.erase_req = 1'b1;
                  s_d.boot      = rbmm_pkg::BT_ERASE;
               end else if (reg_wdata == `RBMM_CMD_CLR_KEEP) begin
                  s_d.boot_code  = 1'b0;
                  s_d.code_clear = 1'b1;
               end
            end
         end
         rbmm_pkg::BT_ERASE: begin
            // code clears only after the erase ends
            if (flash_erase_done) begin
               s_d.erase_req  = 1'b0;
               s_d.boot_code  = 1'b0;
               s_d.code_clear = 1'b1;
               s_d.boot       = rbmm_pkg::BT_FLASH;
            end
         end
         rbmm_pkg::BT_EXT: begin
            s_d.ext_load_req = 1'b1;
         end
         default: begin
            s_d.boot = rbmm_pkg::BT_HOLD;
         end
      endcase

      // utility locked out while code set
      if (ep_wr || ep_rd || ep_erase_spare) begin
         if (s_q.boot_code) begin
            s_d.ep_refused = 1'b1;
            s_d.ep_rdata   = 16'h0000;
         end else if (ep_erase_spare) begin
            s_d.spare = 32'h00000000;
         end else if (ep_addr[`RBMM_EP_SPARE_BIT]) begin
            if (ep_wr) begin
               s_d.spare[ep_addr[1:0]*8 +: 8] = ep_wdata[7:0];
            end
            if (ep_rd) begin
               s_d.ep_rdata = {8'h00, s_q.spare[ep_addr[1:0]*8 +: 8]};
            end
         end else begin
            if (ep_wr) begin
               case (ep_addr[1:0])
                  2'h0:    s_d.fl_ctrl = ep_wdata;
                  2'h1:    s_d.fl_addr = ep_wdata;
                  2'h2:    s_d.fl_dlo  = ep_wdata;
                  default: s_d.fl_dhi  = ep_wdata;
               endcase
            end
            if (ep_rd) begin
               case (ep_addr[1:0])
                  2'h0:    s_d.ep_rdata = s_q.fl_ctrl;
                  2'h1:    s_d.ep_rdata = s_q.fl_addr;
                  2'h2:    s_d.ep_rdata = s_q.fl_dlo;
                  default: s_d.ep_rdata = s_q.fl_dhi;
               endcase
            end
         end
      end

      // software writes
      if (reg_wr) begin
         if (in_peri) begin
            s_d.peri_wr = 1'b1;
         end else if (reg_addr == `RBMM_SYS_CTRL) begin
            s_d.sys_ctrl = reg_wdata;
         end else if (reg_addr == `RBMM_WAIT_CTRL) begin
            s_d.wait_ctrl = reg_wdata;
         end
      end

      // software reads; reserved reads zero
      if (reg_rd) begin
         if (in_peri) begin
            s_d.peri_rd = 1'b1;
            s_d.rdata   = peri_rdata;
         end else if (in_dm_ram) begin
            s_d.rdata = dm_ram[ram_idx];
         end else if (reg_addr >= `RBMM_SPARE_0 &&
                      reg_addr <= `RBMM_SPARE_3) begin
            // spare bytes seen apart from the array
            s_d.rdata = {8'h00, s_q.spare[reg_addr[1:0]*8 +: 8]};
         end else begin
            case (reg_addr)
               `RBMM_BOOT_CTRL: s_d.rdata = {10'h000, s_q.boot, s_q.boot_code};
               `RBMM_FL_CTRL:   s_d.rdata = s_q.fl_ctrl;
               `RBMM_FL_ADDR:   s_d.rdata = s_q.fl_addr;
               `RBMM_FL_DLO:    s_d.rdata = s_q.fl_dlo;
               `RBMM_FL_DHI:    s_d.rdata = s_q.fl_dhi;
               `RBMM_WAIT_CTRL: s_d.rdata = s_q.wait_ctrl;
               `RBMM_SYS_CTRL:  s_d.rdata = s_q.sys_ctrl;
               default:         s_d.rdata = 16'h0000;
            endcase
         end
      end

      // system reset returns control registers to defaults
      if (s_q.rst_hold) begin
         s_d.boot      = rbmm_pkg::BT_HOLD;
         s_d.sys_ctrl  = `RBMM_SYS_RST;
         s_d.wait_ctrl = `RBMM_WAIT_RST;
         s_d.erase_req = 1'b0;
         s_d.peri_wr   = 1'b0;
         s_d.peri_rd   = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q           <= '0;
         s_q.rst_hold  <= 1'b1;
         s_q.boot      <= rbmm_pkg::BT_HOLD;
         s_q.sys_ctrl  <= `RBMM_SYS_RST;
         s_q.wait_ctrl <= `RBMM_WAIT_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata            = s_q.rdata;
   assign peri_wr              = s_q.peri_wr;
   assign peri_rd              = s_q.peri_rd;
   assign pm_sel_ram           = s_q.pm_ram;
   assign pm_sel_rom           = s_q.pm_rom;
   assign pm_sel_flash         = s_q.pm_flash;
   assign pm_sel_rsvd          = s_q.pm_rsvd;
   assign pm_flash_sector      = s_q.pm_sector;
   assign boot_code_clear      = s_q.code_clear;
   assign flash_erase_req      = s_q.erase_req;
   assign ext_load_req         = s_q.ext_load_req;
   assign boot_pc              = s_q.pc;
   assign boot_pc_valid        = s_q.pc_valid;
   assign ep_rdata             = s_q.ep_rdata;
   assign ep_refused           = s_q.ep_refused;
   assign core_reset_n         = !s_q.rst_hold;
   assign periph_reset_n       = !s_q.rst_hold;
   assign cycle_clock_output   = s_q.cyc_pulse;
   assign sync_serial_port_sel = s_q.sys_ctrl[`RBMM_SPORT_BIT];
   assign wait_state_control   = s_q.wait_ctrl;
endmodule

// ==== hdl/rbmm_cfg.svh ====
`ifndef RBMM_CFG_SVH
`define RBMM_CFG_SVH

`define RBMM_AW              14
`define RBMM_DW              16
// program memory map
`define RBMM_PM_RAM_HI       14'h01FF
`define RBMM_PM_ROM_LO       14'h0800
`define RBMM_PM_ROM_HI       14'h17FF
`define RBMM_PM_FL0_LO       14'h2000
`define RBMM_PM_FL1_LO       14'h2100
`define RBMM_PM_FL2_LO       14'h2200
`define RBMM_PM_FL2_HI       14'h2FFF
`define RBMM_SECT0           2'h0
`define RBMM_SECT1           2'h1
`define RBMM_SECT2           2'h2
// boot vectors
`define RBMM_ROM_ENTRY       14'h0800
`define RBMM_FLASH_ENTRY     14'h2200
// data memory map
`define RBMM_DM_PERI_LO      14'h2000
`define RBMM_DM_PERI_HI      14'h20FF
`define RBMM_DM_RAM_LO       14'h3800
`define RBMM_DM_RAM_HI       14'h39FF
`define RBMM_DM_RAM_WORDS    512
`define RBMM_DM_RAM_IW       9
// registers in the upper mapped area
`define RBMM_BOOT_CTRL       14'h3FF0
`define RBMM_SPARE_0         14'h3FF4
`define RBMM_SPARE_3         14'h3FF7
`define RBMM_FL_CTRL         14'h3FF8
`define RBMM_FL_ADDR         14'h3FF9
`define RBMM_FL_DLO          14'h3FFA
`define RBMM_FL_DHI          14'h3FFB
`define RBMM_WAIT_CTRL       14'h3FFE
`define RBMM_SYS_CTRL        14'h3FFF
`define RBMM_WAIT_RST        16'h8000
`define RBMM_SYS_RST         16'h0000
`define RBMM_SPORT_BIT       10
// boot control commands
`define RBMM_CMD_ERASE_CLR   16'h0001
`define RBMM_CMD_CLR_KEEP    16'h0002
// programming-utility port selects
`define RBMM_EP_SPARE_BIT    2
// reset extension after supply good
`define RBMM_POR_EXT_CYCLES  65536
`define RBMM_POR_CW          17

`endif

// ==== hdl/rbmm_pkg.sv ====
package rbmm_pkg;
   typedef enum logic [4:0] {
      BT_HOLD  = 5'b00001,
      BT_ROM   = 5'b00010,
      BT_FLASH = 5'b00100,
      BT_EXT   = 5'b01000,
      BT_ERASE = 5'b10000
   } rbmm_boot_t;

   typedef struct packed {
      logic [16:0] por_cnt;
      logic        rst_hold;
      rbmm_boot_t  boot;
      logic        boot_code;
      logic [13:0] pc;
      logic        pc_valid;
      logic        ext_load_req;
      logic        erase_req;
      logic        code_clear;
      logic [15:0] sys_ctrl;
      logic [15:0] wait_ctrl;
      logic [15:0] fl_ctrl;
      logic [15:0] fl_addr;
      logic [15:0] fl_dlo;
      logic [15:0] fl_dhi;
      logic [31:0] spare;
      logic [15:0] rdata;
      logic        peri_wr;
      logic        peri_rd;
      logic        clk_in_last;
      logic        cyc_pulse;
      logic        pm_ram;
      logic        pm_rom;
      logic        pm_flash;
      logic        pm_rsvd;
      logic [1:0]  pm_sector;
      logic [15:0] ep_rdata;
      logic        ep_refused;
   } rbmm_state_t;
endpackage

// ==== hdl/rbmm_sync.sv ====
module rbmm_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;

   // first stage feeds only the second
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// ==== tb/rbmm_ext_env.sv ====
module rbmm_ext_env #(
   parameter int HALF = 3
) (
   input  wire logic clk,
   input  wire logic pwr_on,
   input  wire logic pin_rst,
   output logic      supply_ok,
   output logic      ext_reset_n,
   output logic      input_clock_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   initial input_clock_pin = 1'b0;
   always @(posedge clk) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1)
         input_clock_pin <= ~input_clock_pin;
   end
   assign supply_ok   = pwr_on;
   assign ext_reset_n = ~pin_rst;
endmodule

// ==== tb/rbmm_top_asserts.sv ====
module rbmm_top_chk #(
   parameter int POR_EXT_CYCLES = 16
) (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        supply_ok,
   input wire logic        ext_reset_n,
   input wire logic        input_clock_pin,
   input wire logic [13:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic        peri_wr,
   input wire logic        peri_rd,
   input wire logic [13:0] pm_addr,
   input wire logic        pm_sel_flash,
   input wire logic        pm_sel_rsvd,
   input wire logic [1:0]  pm_flash_sector,
   input wire logic        boot_code_nv,
   input wire logic        ext_load_req,
   input wire logic [13:0] boot_pc,
   input wire logic        boot_pc_valid,
   input wire logic        ep_rd,
   input wire logic        ep_refused,
   input wire logic        core_reset_n,
   input wire logic        cycle_clock_output,
   input wire logic        sync_serial_port_sel
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [16:0] good_q;
   // raw pins good this long; design sees them later
   always_ff @(posedge clk) begin
      if (!rst_n || !supply_ok || !ext_reset_n)
         good_q <= 17'h0;
      else if (good_q != 17'h1FFFF)
         good_q <= good_q + 17'h1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_peri_write:
   assert property (reg_wr && reg_addr[13:8] == 6'h20 |=> peri_wr)
      else $error("peripheral write strobe missing");
   a_peri_read:
   assert property (reg_rd |=> peri_rd == ($past(reg_addr[13:8]) == 6'h20))
      else $error("peripheral read strobe wrong");
   a_pm_sector_one:
   assert property (pm_addr[13:8] == 6'h21
      |=> pm_sel_flash && pm_flash_sector == 2'h1)
      else $error("flash sector one decode wrong");
   a_pm_reserved:
   assert property (pm_addr inside {[14'h0200:14'h07FF],
      [14'h1800:14'h1FFF], [14'h3000:14'h3FFF]}
      |=> pm_sel_rsvd && !pm_sel_flash)
      else $error("reserved program range decode wrong");
   a_boot_entry:
   assert property ($rose(core_reset_n)
      |-> ##[0:2] (boot_pc_valid && boot_pc == 14'h0800))
      else $error("boot does not start at rom entry");
   a_boot_path:
   assert property ($rose(boot_pc_valid) |-> ##[1:3]
      (boot_code_nv ? boot_pc == 14'h2200 : ext_load_req))
      else $error("boot path after monitor wrong");
   a_ep_locked:
   assert property (ep_rd && boot_code_nv && boot_pc_valid
      && boot_pc == 14'h2200 |=> ep_refused)
      else $error("utility access not refused");
   a_cycle_clock:
   assert property ($changed(input_clock_pin) && core_reset_n
      |-> ##[1:4] cycle_clock_output)
      else $error("cycle clock pulse missing");
   a_pin_reset:
   assert property (!ext_reset_n |-> ##[1:4] !core_reset_n)
      else $error("pin reset not taken");
   a_por_count:
   assert property ($rose(core_reset_n) |-> good_q >= POR_EXT_CYCLES)
      else $error("reset released early");
   a_sport_bit:
   assert property (reg_wr && reg_addr == 14'h3FFF && core_reset_n
      |=> sync_serial_port_sel == $past(reg_wdata[10]))
      else $error("serial port select wrong");
endmodule

bind rbmm_top rbmm_top_chk #(.POR_EXT_CYCLES(POR_EXT_CYCLES)) i_rbmm_top_chk (
   .clk, .rst_n, .supply_ok, .ext_reset_n, .input_clock_pin, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .peri_wr, .peri_rd, .pm_addr, .pm_sel_flash,
   .pm_sel_rsvd, .pm_flash_sector, .boot_code_nv, .ext_load_req, .boot_pc,
   .boot_pc_valid, .ep_rd, .ep_refused, .core_reset_n, .cycle_clock_output,
   .sync_serial_port_sel);

// ==== tb/testbench.sv ====
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int N = 16;
   typedef struct {
      logic [13:0] a;
      logic [15:0] d;
      logic [15:0] e;
      logic [13:0] p;
      logic [15:0] s;
   } rbmm_row_t;
   logic        clk = 1'b0;
   logic        rst_n, pwr_on, pin_rst, supply_ok, ext_reset_n;
   logic        input_clock_pin, reg_wr, reg_rd, peri_wr, peri_rd;
   logic [13:0] reg_addr, pm_addr, boot_pc;
   logic [15:0] reg_wdata, reg_rdata, peri_rdata, ep_wdata, ep_rdata;
   logic [15:0] wait_state_control;
   logic        pm_sel_ram, pm_sel_rom, pm_sel_flash, pm_sel_rsvd;
   logic [1:0]  pm_flash_sector;
   logic        boot_code_nv, boot_code_clear, flash_erase_req;
   logic        flash_erase_done, ext_load_req, boot_pc_valid;
   logic        ep_wr, ep_rd, ep_erase_spare, ep_refused;
   logic [2:0]  ep_addr;
   logic        core_reset_n, periph_reset_n, cycle_clock_output;
   logic        sync_serial_port_sel;
   int          n_errors = 0;
   int          compares = 0;
   // reg side and program decode side share each row
   rbmm_row_t rows[13] = '{
      '{14'h3800, 16'h1234, 16'h1234, 14'h0000, 16'h0020},
      '{14'h39FF, 16'hABCD, 16'hABCD, 14'h01FF, 16'h0020},
      '{14'h0100, 16'h5555, 16'h0000, 14'h0200, 16'h0004},
      '{14'h3A00, 16'h5555, 16'h0000, 14'h0800, 16'h0010},
      '{14'h3BFF, 16'h5555, 16'h0000, 14'h17FF, 16'h0010},
      '{14'h1FFF, 16'h5555, 16'h0000, 14'h1800, 16'h0004},
      '{14'h2100, 16'h5555, 16'h0000, 14'h2000, 16'h0008},
      '{14'h37FF, 16'h5555, 16'h0000, 14'h20FF, 16'h0008},
      '{14'h0000, 16'h5555, 16'h0000, 14'h2100, 16'h0009},
      '{14'h3FFF, 16'h0400, 16'h0400, 14'h21FF, 16'h0009},
      '{14'h3FFF, 16'h0000, 16'h0000, 14'h2200, 16'h000A},
      '{14'h3FFE, 16'h8000, 16'h8000, 14'h2FFF, 16'h000A},
      '{14'h3800, 16'hFFFF, 16'hFFFF, 14'h3000, 16'h0004}};

   always #4 clk = ~clk;

   rbmm_top #(.POR_EXT_CYCLES(N)) i_rbmm_top (
      .clk, .rst_n, .supply_ok, .ext_reset_n, .input_clock_pin, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .peri_rdata, .peri_wr,
      .peri_rd, .pm_addr, .pm_sel_ram, .pm_sel_rom, .pm_sel_flash,
      .pm_sel_rsvd, .pm_flash_sector, .boot_code_nv, .boot_code_clear,
      .flash_erase_req, .flash_erase_done, .ext_load_req, .boot_pc,
      .boot_pc_valid, .ep_wr, .ep_rd, .ep_erase_spare, .ep_addr, .ep_wdata,
      .ep_rdata, .ep_refused, .core_reset_n, .periph_reset_n,
      .cycle_clock_output, .sync_serial_port_sel, .wait_state_control);
   rbmm_ext_env i_rbmm_ext_env (
      .clk, .pwr_on, .pin_rst, .supply_ok, .ext_reset_n, .input_clock_pin);

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [13:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [13:0] a, output logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // k: bit0 write, bit1 read, bit2 spare erase
   task automatic ep(input logic [2:0] k, a, input logic [15:0] d);
      @(posedge clk);
      {ep_erase_spare, ep_rd, ep_wr} <= k;
      ep_addr <= a;
      ep_wdata <= d;
      @(posedge clk);
      {ep_erase_spare, ep_rd, ep_wr} <= 3'h0;
      #1;
   endtask
   task automatic boot;
      int n;
      n = 0;
      while (core_reset_n !== 1'b1 && n < 300) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(16'(core_reset_n === 1'b1 && n >= N), 16'h1);
      repeat (3) @(posedge clk);
      #1;
      if (boot_code_nv)
         chk(16'(boot_pc), 16'h2200);
      else
         chk(16'(ext_load_req), 16'h1);
   endtask
   task automatic pin_reset;
      @(posedge clk);
      pin_rst <= 1'b1;
      repeat (5) @(posedge clk);
      #1;
      chk(16'({core_reset_n, periph_reset_n}), 16'h0);
      pin_rst <= 1'b0;
      // drop again mid-count: the count must start over
      repeat (N / 2) @(posedge clk);
      pin_rst <= 1'b1;
      repeat (3) @(posedge clk);
      pin_rst <= 1'b0;
      boot();
   endtask
   task tally_and_finish;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial begin
      repeat (6000) @(posedge clk);
      n_errors++;
      tally_and_finish();
   end

   initial begin
      logic [15:0] v;
      logic [15:0] w;
      int c;
      {rst_n, pwr_on, pin_rst, reg_wr, reg_rd, ep_wr, ep_rd} = '0;
      {ep_erase_spare, boot_code_nv, flash_erase_done} = '0;
      {reg_addr, pm_addr, reg_wdata, ep_wdata, ep_addr} = '0;
      peri_rdata = 16'h5A3C;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      pwr_on <= 1'b1;
      boot();
      rd(14'h3FFE, v);
      chk(v, 16'h8000);
      $display("power-on boot done");
      foreach (rows[i]) begin
         @(posedge clk);
         pm_addr <= rows[i].p;
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, v);
         chk(v, rows[i].e);
         w = {pm_sel_ram, pm_sel_rom, pm_sel_flash, pm_sel_rsvd, 2'h0};
         w[1:0] = pm_flash_sector & {2{pm_sel_flash}};
         chk(w, rows[i].s);
      end
      $display("row table done");
      wr(14'h2000, 16'h1111);
      chk(16'(peri_wr), 16'h1);
      rd(14'h20FF, v);
      chk({v[14:0], peri_rd}, {peri_rdata[14:0], 1'b1});
      ep(3'h1, 3'h0, 16'hC35A);
      rd(14'h3FF8, v);
      chk(v, 16'hC35A);
      wr(14'h3FF8, ~v);
      rd(14'h3FF8, w);
      chk(w, v);
      wr(14'h3FF0, 16'h0001);
      chk(16'(flash_erase_req), 16'h0);
      ep(3'h1, 3'h5, 16'h00AB);
      rd(14'h3FF5, v);
      chk(v, 16'h00AB);
      ep(3'h4, 3'h0, 16'h0);
      ep(3'h2, 3'h5, 16'h0);
      chk(ep_rdata, 16'h0);
      c = 0;
      repeat (60) begin
         @(posedge clk);
         #1 c += cycle_clock_output;
      end
      chk(16'(c >= 19 && c <= 21), 16'h1);
      $display("decode and clock done");
      // only the port select bit set
      wr(14'h3FFF, 16'h0400);
      chk({15'h0, sync_serial_port_sel}, 16'h1);
      // image assumed loaded at flash entry
      boot_code_nv <= 1'b1;
      pin_reset();
      chk({15'h0, sync_serial_port_sel}, 16'h0);
      chk(wait_state_control, 16'h8000);
      ep(3'h2, 3'h4, 16'h0);
      chk({ep_rdata[14:0], ep_refused}, 16'h1);
      wr(14'h3FF0, 16'h0001);
      chk(16'(flash_erase_req), 16'h1);
      repeat (4) @(posedge clk);
      flash_erase_done <= 1'b1;
      @(posedge clk);
      flash_erase_done <= 1'b0;
      #1;
      chk(16'({boot_code_clear, flash_erase_req}), 16'h2);
      boot_code_nv <= 1'b0;
      $display("erase and clear done");
      @(posedge clk);
      boot_code_nv <= 1'b1;
      pin_reset();
      wr(14'h3FF0, 16'h0002);
      chk(16'({boot_code_clear, flash_erase_req}), 16'h2);
      boot_code_nv <= 1'b0;
      $display("clear keep done");
      tally_and_finish();
   end
endmodule
